/* File: logic/memory_size_config_pkg.sv */
// Package for the memory size configuration register bank.
// Assumes an 8-bit special function register access path with 16-bit addresses.
package memory_size_config_pkg;

  localparam logic [15:0] MEMORY_SIZE_SELECT_ADDR        = 16'hfff0;
  localparam logic [15:0] EXPANSION_RAM_SIZE_SELECT_ADDR = 16'hfff4;

  localparam logic [7:0]  MEMORY_SIZE_SELECT_RESET        = 8'hcc;
  localparam logic [7:0]  EXPANSION_RAM_SIZE_SELECT_RESET = 8'h0c;

  // Writable bits; the rest are fixed at zero.
  localparam logic [7:0]  MEMORY_SIZE_SELECT_MASK        = 8'hef;
  localparam logic [7:0]  EXPANSION_RAM_SIZE_SELECT_MASK = 8'h1f;

  localparam int          HSRAM_SIZE_LSB = 5;
  localparam int          ROM_SIZE_LSB   = 0;
  localparam int          XRAM_CAP_LSB   = 0;

  localparam logic [2:0]  HSRAM_SIZE_1024 = 3'h6;
  localparam logic [3:0]  ROM_SIZE_48K    = 4'hc;
  localparam logic [3:0]  ROM_SIZE_60K    = 4'hf;
  localparam logic [4:0]  XRAM_CAP_512    = 5'h0b;

endpackage

/* File: logic/memory_size_config_regs.sv */
// Memory size selection and expansion RAM size selection registers.
// Assumes one-cycle byte read and write strobes from the CPU on the same clock.
`timescale 1ns/10ps

// How it works
// - Size select at FFF0H, 8-bit read/write, resets to CCH, bit 4 zero.
// - Bits 7..5 pick high-speed RAM size; only 110 (1024 bytes) allowed.
// - Bits 3..0 pick ROM size; 1100 is 48K, 1111 is 60K only.
// - Expansion select at FFF4H, 8-bit read/write, resets to 0CH, bits 7..5 zero.
// - Bits 4..0 pick expansion RAM size; only 01011 (512 bytes) allowed.
// - Without expansion select present, writes to its address change nothing.
module memory_size_config_regs #(
  parameter bit HAS_EXPANSION_SELECT = 1'b1
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // CPU special function register access
  input  wire logic [15:0] address,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  input  wire logic [7:0]  writeData,
  output logic      [7:0]  readData,
  output logic             readHit,
  // Decoded memory map configuration
  output logic      [2:0]  hsramSize,
  output logic      [3:0]  romSize,
  output logic      [4:0]  xramCap,
  output logic             hsramSizeValid,
  output logic             romSizeValid,
  output logic             xramCapValid
);

  // Register state: one group per register, plus the read data stage.
  logic [7:0] memorySizeSelect_reg;
  logic [7:0] memorySizeSelect_next;
  logic [7:0] expansionRamSizeSelect_reg;
  logic [7:0] expansionRamSizeSelect_next;
  logic [7:0] readData_reg;
  logic [7:0] readData_next;
  logic       hitMemory;
  logic       hitExpansion;
  logic       writeMemory;
  logic       writeExpansion;
  logic       readMemory;
  logic       readExpansion;

  // One decode serves reads and writes, so both always agree on what is mapped.
  assign hitMemory    = (address == memory_size_config_pkg::MEMORY_SIZE_SELECT_ADDR);
  assign hitExpansion = HAS_EXPANSION_SELECT
                      && (address == memory_size_config_pkg::EXPANSION_RAM_SIZE_SELECT_ADDR);

  assign writeMemory    = writeStrobe && hitMemory;
  // An absent register never decodes, so its writes are dropped and disturb nothing.
  assign writeExpansion = writeStrobe && hitExpansion;
  assign readMemory     = readStrobe && hitMemory;
  assign readExpansion  = readStrobe && hitExpansion;

  // Memory size select register.
  always_comb begin
    memorySizeSelect_next = memorySizeSelect_reg;
    if (writeMemory) begin
      // Bit 4 is forced low so the fixed bit can never be set.
      memorySizeSelect_next =
        writeData & memory_size_config_pkg::MEMORY_SIZE_SELECT_MASK;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      memorySizeSelect_reg <= memory_size_config_pkg::MEMORY_SIZE_SELECT_RESET;
    end else begin
      memorySizeSelect_reg <= memorySizeSelect_next;
    end
  end

  // Expansion RAM size select register.
  always_comb begin
    expansionRamSizeSelect_next = expansionRamSizeSelect_reg;
    if (writeExpansion) begin
      // Bits 7 to 5 are forced low; prohibited size patterns are still stored.
      expansionRamSizeSelect_next =
        writeData & memory_size_config_pkg::EXPANSION_RAM_SIZE_SELECT_MASK;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      expansionRamSizeSelect_reg <=
        memory_size_config_pkg::EXPANSION_RAM_SIZE_SELECT_RESET;
    end else begin
      expansionRamSizeSelect_reg <= expansionRamSizeSelect_next;
    end
  end

  // Read data stage; it shows 00 in every cycle that follows no mapped read.
  always_comb begin
    readData_next = 8'h00;
    if (readMemory) begin
      readData_next = memorySizeSelect_reg;
    end else if (readExpansion) begin
      readData_next = expansionRamSizeSelect_reg;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readData_reg <= 8'h00;
    end else begin
      readData_reg <= readData_next;
    end
  end

  // A read in the same cycle as a write returns the value from before the write.
  assign readData = readData_reg;
  assign readHit  = readMemory || readExpansion;

  assign hsramSize =
    memorySizeSelect_reg[memory_size_config_pkg::HSRAM_SIZE_LSB +: 3];
  assign romSize   =
    memorySizeSelect_reg[memory_size_config_pkg::ROM_SIZE_LSB +: 4];
  assign xramCap   =
    expansionRamSizeSelect_reg[memory_size_config_pkg::XRAM_CAP_LSB +: 5];

  // Prohibited patterns are flagged rather than corrected, so software faults stay visible.
  assign hsramSizeValid = (hsramSize == memory_size_config_pkg::HSRAM_SIZE_1024);
  assign romSizeValid   = (romSize == memory_size_config_pkg::ROM_SIZE_48K)
                        || (romSize == memory_size_config_pkg::ROM_SIZE_60K);
  // The reset value is not a legal size until initialisation software rewrites it.
  assign xramCapValid   = (xramCap == memory_size_config_pkg::XRAM_CAP_512);

  // Expected values below are plain bytes, kept apart from the package on purpose.
  a_mem_bit4_zero: assert property (@(posedge clock) disable iff (!reset_n)
    memorySizeSelect_reg[4] == 1'b0)
    else $error("memory size select bit 4 is set");

  a_mem_write_stores: assert property (@(posedge clock) disable iff (!reset_n)
    writeMemory |=> memorySizeSelect_reg == ($past(writeData) & 8'hef))
    else $error("memory size select write not stored");

  a_mem_hold_idle: assert property (@(posedge clock) disable iff (!reset_n)
    !writeMemory |=> $stable(memorySizeSelect_reg))
    else $error("memory size select changed without a write");

  a_mem_hit_decode: assert property (@(posedge clock) disable iff (!reset_n)
    readStrobe && address == 16'hfff0 |-> readHit)
    else $error("memory size select read not decoded");

  a_xram_high_zero: assert property (@(posedge clock) disable iff (!reset_n)
    expansionRamSizeSelect_reg[7:5] == 3'h0)
    else $error("expansion select upper bits set");

  a_xram_write_stores: assert property (@(posedge clock) disable iff (!reset_n)
    writeExpansion |=> expansionRamSizeSelect_reg == ($past(writeData) & 8'h1f))
    else $error("expansion select write not stored");

  a_xram_hold_idle: assert property (@(posedge clock) disable iff (!reset_n)
    !writeExpansion |=> $stable(expansionRamSizeSelect_reg))
    else $error("expansion select changed without a write");

  a_xram_hit_decode: assert property (@(posedge clock) disable iff (!reset_n)
    HAS_EXPANSION_SELECT && readStrobe && address == 16'hfff4 |-> readHit)
    else $error("expansion select read not decoded");

  a_xram_absent_hold: assert property (@(posedge clock) disable iff (!reset_n)
    !HAS_EXPANSION_SELECT |=> $stable(expansionRamSizeSelect_reg))
    else $error("absent expansion select changed");

  a_absent_no_hit: assert property (@(posedge clock) disable iff (!reset_n)
    !HAS_EXPANSION_SELECT && readStrobe && address == 16'hfff4 |-> !readHit)
    else $error("absent expansion select answered a read");

  a_xram_write_isolated: assert property (@(posedge clock) disable iff (!reset_n)
    writeStrobe && address == 16'hfff4 |=> $stable(memorySizeSelect_reg))
    else $error("expansion address write disturbed memory size select");

  a_unmapped_no_hit: assert property (@(posedge clock) disable iff (!reset_n)
    readStrobe && address != 16'hfff0 && address != 16'hfff4 |-> !readHit)
    else $error("unmapped address answered a read");

  a_read_returns: assert property (@(posedge clock) disable iff (!reset_n)
    readMemory |=> readData == $past(memorySizeSelect_reg))
    else $error("memory size select read mismatch");

  a_xram_read_returns: assert property (@(posedge clock) disable iff (!reset_n)
    readExpansion |=> readData == $past(expansionRamSizeSelect_reg))
    else $error("expansion select read mismatch");

  a_read_idle_zero: assert property (@(posedge clock) disable iff (!reset_n)
    !readHit |=> readData == 8'h00)
    else $error("read data not zero after an unanswered cycle");

  a_hsram_valid: assert property (@(posedge clock) disable iff (!reset_n)
    hsramSizeValid == (memorySizeSelect_reg[7:5] == 3'h6))
    else $error("high-speed RAM valid flag wrong");

  a_rom_valid: assert property (@(posedge clock) disable iff (!reset_n)
    romSizeValid == (memorySizeSelect_reg[3:0] == 4'hc || memorySizeSelect_reg[3:0] == 4'hf))
    else $error("ROM valid flag wrong");

  a_xram_valid: assert property (@(posedge clock) disable iff (!reset_n)
    xramCapValid == (expansionRamSizeSelect_reg[4:0] == 5'h0b))
    else $error("expansion RAM valid flag wrong");

  a_field_slices: assert property (@(posedge clock) disable iff (!reset_n)
    hsramSize == memorySizeSelect_reg[7:5] && romSize == memorySizeSelect_reg[3:0])
    else $error("memory size fields do not follow the register");

  a_xram_slice: assert property (@(posedge clock) disable iff (!reset_n)
    xramCap == expansionRamSizeSelect_reg[4:0])
    else $error("expansion RAM field does not follow the register");

  // Main scenarios that the bench is expected to reach.
  c_write_cfh: cover property (@(posedge clock) disable iff (!reset_n)
    writeMemory && writeData == 8'hcf);
  c_write_0bh: cover property (@(posedge clock) disable iff (!reset_n)
    writeExpansion && writeData == 8'h0b);
  c_read_xram: cover property (@(posedge clock) disable iff (!reset_n)
    readExpansion);
  c_read_during_write: cover property (@(posedge clock) disable iff (!reset_n)
    readMemory && writeMemory);
  c_unmapped_read: cover property (@(posedge clock) disable iff (!reset_n)
    readStrobe && !readHit);

endmodule

/* File: sim/memory_size_config_regs_tb.sv */
// Self-checking bench for the memory size configuration register bank.
// Assumes one-cycle strobes and read data registered at the strobe edge.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module memory_size_config_regs_tb;
  logic        clock, reset_n, writeStrobe, readStrobe, readHit, hit, hsOk, romOk, xOk;
  logic [15:0] address;
  logic [7:0]  writeData, readData, rd2, q, q2;
  logic [2:0]  hsramSize;
  logic [3:0]  romSize, rom_size_bit2;
  logic [4:0]  xramCap;
  int          n_fail, compares, cycles;
  // Each row: address, byte written, byte read back, expected hit.
  logic [32:0] rows [5] = '{{16'hfff0, 8'hff, 8'hef, 1'b1}, {16'hfff4, 8'hff, 8'h1f, 1'b1},
    {16'hfff2, 8'h55, 8'h00, 1'b0}, {16'hfff0, 8'hcf, 8'hcf, 1'b1},
    {16'hfff4, 8'h0b, 8'h0b, 1'b1}};
  memory_size_config_regs dut_u (.clock(clock), .reset_n(reset_n), .address(address),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .writeData(writeData),
    .readData(readData), .readHit(readHit), .hsramSize(hsramSize), .romSize(romSize),
    .xramCap(xramCap), .hsramSizeValid(hsOk), .romSizeValid(romOk), .xramCapValid(xOk));
  // Variant without the expansion register shares every input with the first.
  memory_size_config_regs #(.HAS_EXPANSION_SELECT(1'b0)) dut_v (.clock(clock),
    .reset_n(reset_n), .address(address), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .writeData(writeData), .readData(rd2), .readHit(),
    .hsramSize(), .romSize(rom_size_bit2), .xramCap(), .hsramSizeValid(), .romSizeValid(),
    .xramCapValid());
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic complete_run;
    $display("counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // The ceiling is generous: the whole sequence needs well under 100 cycles.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock) {address, writeData, writeStrobe} = {a, d, 1'b1};
    @(negedge clock) writeStrobe = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clock) {address, readStrobe} = {a, 1'b1};
    #1 hit = readHit;
    @(negedge clock) readStrobe = 1'b0;
    {q, q2} = {readData, rd2};
  endtask
  initial begin
    {reset_n, writeStrobe, readStrobe, address, writeData} = '0;
    repeat (12) @(posedge clock);
    @(negedge clock) reset_n = 1'b1;
    `CHK({hsramSize, romSize, xramCap, xOk}, {3'h6, 4'hc, 5'h0c, 1'b0})
    rd(16'hfff0);
    `CHK(q, 8'hcc)
    rd(16'hfff4);
    `CHK(q, 8'h0c)
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][32:17], rows[i][16:9]);
      rd(rows[i][32:17]);
      `CHK(q, rows[i][8:1])
      `CHK(hit, rows[i][0])
      if (rows[i][32:17] == 16'hfff4) `CHK(q2, 8'h00)
    end
    `CHK({hsramSize, romSize, xramCap}, {3'h6, 4'hf, 5'h0b})
    `CHK({hsOk, romOk, xOk, rom_size_bit2}, {3'b111, 4'hf})
    $display("table test done");
    @(negedge clock) {address, writeData, writeStrobe, readStrobe} = {16'hfff0, 8'h20, 2'b11};
    @(negedge clock) {writeStrobe, readStrobe} = 2'b00;
    `CHK(readData, 8'hcf)
    `CHK({hsramSize, romSize, hsOk, romOk}, {3'h1, 4'h0, 2'b00})
    wr(16'hfff0, 8'hcc);
    `CHK({romSize, romOk}, {4'hc, 1'b1})
    $display("same-cycle test done");
    @(negedge clock) reset_n = 1'b0;
    @(negedge clock) reset_n = 1'b1;
    `CHK({xramCap, xOk, romSize}, {5'h0c, 1'b0, 4'hc})
    $display("second reset test done");
    complete_run();
  end
endmodule
